// [verilog/ledd_core.sv]
// LED driver serial input, latch, PWM, error and APB status logic
`timescale 1ns/1ps
module ledd_core (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shiftClk,
  input  wire logic        serialIn,
  input  wire logic        latchStrobe,
  input  wire logic        blank,
  input  wire logic        modeSelect,
  input  wire logic        pwmRefClock,
  input  wire logic        overTemp,
  input  wire logic [15:0] openSense,
  input  wire logic        errorOutNIn,
  output logic             serialOut,
  output logic             errorOutNOut,
  output logic             errorOutNOe,
  output logic [15:0]      channelOutput
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 24;
  logic [NPIN-1:0] pinRaw;     // All asynchronous pins
  logic [NPIN-1:0] syncA_ff;   // First stage, read only by syncB_ff
  logic [NPIN-1:0] syncB_ff;   // Second stage, safe to use
  logic [NPIN-1:0] prevB_ff;   // Delayed copy for edge detection

  assign pinRaw = {errorOutNIn, openSense, overTemp, pwmRefClock,
                   modeSelect, blank, latchStrobe, serialIn, shiftClk};

  // Two flops before any logic looks at a pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      prevB_ff <= '0;
    end else begin
      syncA_ff <= pinRaw;
      syncB_ff <= syncA_ff;
      prevB_ff <= syncB_ff;
    end
  end

  logic        shiftRise;   // Shift clock rising edge
  logic        serInS;      // Synchronised serial data
  logic        latchHigh;   // Strobe level
  logic        latchFall;   // Strobe high to low
  logic        blankS;      // Blanking pin level
  logic        modeDc;      // Dot-correction input mode
  logic        pwmRise;     // Grayscale reference edge
  logic        thermal;     // Thermal flag
  logic [15:0] openS;       // Per-channel low-voltage sense
  logic        errPinS;     // Level seen on the error wire

  assign shiftRise = syncB_ff[0] & ~prevB_ff[0];
  assign serInS    = syncB_ff[1];
  assign latchHigh = syncB_ff[2];
  assign latchFall = ~syncB_ff[2] & prevB_ff[2];
  assign blankS    = syncB_ff[3];
  assign modeDc    = syncB_ff[4]; // Tied high selects dot correction
  assign pwmRise   = syncB_ff[5] & ~prevB_ff[5];
  assign thermal   = syncB_ff[6]; // Follows the indication both ways
  assign openS     = syncB_ff[22:7];
  assign errPinS   = syncB_ff[23];

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  ledd_pkg::ledd_apb_e apbSt_ff;  // Slave state
  logic [1:0]  ctrl_ff;           // Control bits
  logic [31:0] prdata_ff;         // Read data
  logic        pready_ff;         // Ready, one cycle per access
  logic        pslverr_ff;        // Unmapped address answer
  logic        errEn;             // Error output allowed
  logic        blankEff;          // Pin or software blanking
  logic [15:0] lodBits_ff;        // Live open-LED errors
  logic [11:0] pwmCnt_ff;         // Grayscale counter
  logic [31:0] rdMux;             // Read data before the flop
  logic        adrOk;             // Address is mapped

  assign errEn    = ctrl_ff[ledd_pkg::CTRL_ERR_EN];
  assign blankEff = blankS | ctrl_ff[ledd_pkg::CTRL_FRC_BLANK];

  // Read decode
  always_comb begin
    rdMux = 32'h0000_0000;
    adrOk = 1'b1;
    case (paddr)
      ledd_pkg::ADR_CTRL: begin
        rdMux[1:0] = ctrl_ff;
      end
      ledd_pkg::ADR_STATUS: begin
        rdMux[ledd_pkg::ST_THERM]  = thermal;
        rdMux[ledd_pkg::ST_OPEN]   = |lodBits_ff;
        rdMux[ledd_pkg::ST_MODE]   = modeDc;
        rdMux[ledd_pkg::ST_BLANK]  = blankEff;
        rdMux[ledd_pkg::ST_ERRPIN] = errPinS;
      end
      ledd_pkg::ADR_LOD: begin
        rdMux[15:0] = lodBits_ff;
      end
      ledd_pkg::ADR_PWMCNT: begin
        rdMux[11:0] = pwmCnt_ff;
      end
      default: begin
        adrOk = 1'b0;
      end
    endcase
  end

  // One wait state; the write lands on the edge that sees pready
  always_ff @(posedge mclk) begin
    if (rst) begin
      apbSt_ff   <= ledd_pkg::AP_IDLE;
      ctrl_ff    <= ledd_pkg::CTRL_RST;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      case (apbSt_ff)
        ledd_pkg::AP_IDLE: begin
          if (psel && penable) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : rdMux;
            pslverr_ff <= ~adrOk;
            pready_ff  <= 1'b1;
            apbSt_ff   <= ledd_pkg::AP_RESP;
          end
        end
        ledd_pkg::AP_RESP: begin
          // Request is still held by the master here
          if (pwrite && paddr == ledd_pkg::ADR_CTRL) begin
            ctrl_ff <= pwdata[1:0];
          end
          pready_ff  <= 1'b0;
          pslverr_ff <= 1'b0;
          apbSt_ff   <= ledd_pkg::AP_IDLE;
        end
        default: begin
          pready_ff <= 1'b0;
          apbSt_ff  <= ledd_pkg::AP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Shift register and data latches
  // ----------------------------------------
  logic [191:0] sr_ff;      // Input shift register
  logic [191:0] gsReg_ff;   // Active grayscale values
  logic [95:0]  dcReg_ff;   // Dot-correction values
  logic [191:0] sidWord;    // Status readback image

  // Status image: open bits on top, thermal flag below them
  always_comb begin
    sidWord = '0;
    sidWord[ledd_pkg::SID_LOD_MSB -: 16] = lodBits_ff;
    sidWord[ledd_pkg::SID_TEF] = thermal;
  end

  // Strobe fall reloads the shifter with status; wins over a shift
  always_ff @(posedge mclk) begin
    if (rst) begin
      sr_ff <= '0;
    end else if (latchFall) begin
      sr_ff <= sidWord;
    end else if (shiftRise) begin
      sr_ff <= {sr_ff[190:0], serInS};
    end
  end

  // Level-sensitive latch, so the register follows the shifter
  always_ff @(posedge mclk) begin
    if (rst) begin
      gsReg_ff <= '0;
      dcReg_ff <= '0;
    end else if (latchHigh) begin
      if (modeDc) begin
        dcReg_ff <= sr_ff[95:0];
      end else begin
        gsReg_ff <= sr_ff;
      end
    end
  end

  // Tap point gives the chain length of the current mode
  logic serialOut_ff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      serialOut_ff <= 1'b0;
    end else begin
      serialOut_ff <= modeDc ? sr_ff[ledd_pkg::SR_DC-1]
                             : sr_ff[ledd_pkg::SR_GS-1];
    end
  end

  // ----------------------------------------
  // Grayscale PWM
  // ----------------------------------------
  // Counter runs on reference edges, held at zero while blanked
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwmCnt_ff <= 12'h000;
    end else if (blankEff) begin
      pwmCnt_ff <= 12'h000;
    end else if (pwmRise && pwmCnt_ff != 12'(ledd_pkg::PWM_MAX)) begin
      pwmCnt_ff <= pwmCnt_ff + 12'h001;
    end
  end

  ledd_chan_if chIf ();

  // Gate before the delay line: a short low gap keeps its width
  // for every channel, even when it emerges after blanking returns
  always_comb begin
    for (int n = 0; n < ledd_pkg::NCH; n++) begin
      chIf.rawOn[n] = ~blankEff &&
                      (pwmCnt_ff < gsReg_ff[n*ledd_pkg::GS_W +: ledd_pkg::GS_W]);
    end
  end

  ledd_stagger uStagger (
    .mclk (mclk),
    .rst  (rst),
    .ch   (chIf.stg)
  );

  // Registered channel drive
  logic [15:0] chanOut_ff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      chanOut_ff <= 16'h0000;
    end else begin
      chanOut_ff <= chIf.chanOn;
    end
  end

  // ----------------------------------------
  // Open-LED detection and error pin
  // ----------------------------------------
  logic [6:0] onTime_ff [0:15];  // Cycles each channel has been on

  // Error only after the channel has been on long enough
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int n = 0; n < ledd_pkg::NCH; n++) begin
        onTime_ff[n] <= 7'h00;
      end
      lodBits_ff <= 16'h0000;
    end else begin
      for (int n = 0; n < ledd_pkg::NCH; n++) begin
        if (!chanOut_ff[n]) begin
          onTime_ff[n] <= 7'h00;
        end else if (onTime_ff[n] != 7'(ledd_pkg::LOD_CYC)) begin
          onTime_ff[n] <= onTime_ff[n] + 7'h01;
        end
        lodBits_ff[n] <= chanOut_ff[n] && openS[n] &&
                         onTime_ff[n] == 7'(ledd_pkg::LOD_CYC);
      end
    end
  end

  // Pull low on thermal, or on open LED unless blanked
  logic errOe_ff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      errOe_ff <= 1'b0;
    end else begin
      errOe_ff <= errEn && (thermal ||
                            ((|lodBits_ff) && !blankEff));
    end
  end

  // Open drain: the driven level is always low
  logic errOut_ff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      errOut_ff <= 1'b0;
    end else begin
      errOut_ff <= 1'b0;
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign serialOut     = serialOut_ff;
  assign errorOutNOut  = errOut_ff;
  assign errorOutNOe   = errOe_ff;
  assign channelOutput = chanOut_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SHIFT_IN: assert property (@(posedge mclk) disable iff (rst)
    shiftRise && !latchFall |=> sr_ff[0] == $past(serInS) &&
      sr_ff[191:1] == $past(sr_ff[190:0]))
    else $error("Shift did not take serial bit");
  AST_GS_LATCH: assert property (@(posedge mclk) disable iff (rst)
    latchHigh && !modeDc |=> gsReg_ff == $past(sr_ff))
    else $error("Grayscale latch not transparent");
  AST_DC_LATCH: assert property (@(posedge mclk) disable iff (rst)
    latchHigh && modeDc |=> dcReg_ff == $past(sr_ff[95:0]) && $stable(gsReg_ff))
    else $error("Dot-correction latch wrong");
  AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !latchHigh |=> $stable(gsReg_ff) && $stable(dcReg_ff))
    else $error("Latch changed while strobe low");
  AST_SERIAL_OUT: assert property (@(posedge mclk) disable iff (rst)
    ##1 serialOut == ($past(modeDc) ? $past(sr_ff[95]) : $past(sr_ff[191])))
    else $error("Serial output tap wrong");
  AST_SID: assert property (@(posedge mclk) disable iff (rst)
    latchFall |=> sr_ff[191:176] == $past(lodBits_ff) && sr_ff[175] == $past(thermal))
    else $error("Status not captured on strobe fall");
  AST_THERM_ERR: assert property (@(posedge mclk) disable iff (rst)
    errEn && thermal |=> errorOutNOe && !errorOutNOut)
    else $error("Thermal flag did not pull error low");
  AST_BLANK_MASK: assert property (@(posedge mclk) disable iff (rst)
    blankEff && !thermal |=> !errorOutNOe)
    else $error("Open flag not masked by blanking");
  AST_LOD_TIME: assert property (@(posedge mclk) disable iff (rst)
    !chanOut_ff[0] |=> !lodBits_ff[0] [*2])
    else $error("Open error without on time");
  AST_BLANK_OFF: assert property (@(posedge mclk) disable iff (rst)
    blankEff |-> chIf.rawOn == 16'h0000 ##1 pwmCnt_ff == 12'h000)
    else $error("Blanking did not clear counter and outputs");

endmodule

// [shared/ledd_pkg.sv]
// Constants shared by the LED driver control logic
package ledd_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NCH   = 16;  // Output channels
  localparam int GS_W  = 12;  // Grayscale bits per channel
  localparam int DC_W  = 6;   // Dot-correction bits per channel
  localparam int SR_GS = 192; // Shift length in grayscale mode
  localparam int SR_DC = 96;  // Shift length in dot-correction mode

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS   = 8;    // mclk period
  localparam int STEP_NS  = 20;   // Stagger step between channels
  localparam int LOD_NS   = 1000; // Open-detect delay
  // Least time, so round up
  localparam int LOD_CYC  = (LOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_DLY  = ((NCH - 1) * STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWM_MAX  = (1 << GS_W) - 1; // Counter saturates here

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_LOD    = 8'h08;
  localparam logic [7:0] ADR_PWMCNT = 8'h0c;
  localparam int CTRL_ERR_EN    = 0;  // Error output enable
  localparam int CTRL_FRC_BLANK = 1;  // Software blanking
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int ST_THERM  = 0;
  localparam int ST_OPEN   = 1;
  localparam int ST_MODE   = 2;
  localparam int ST_BLANK  = 3;
  localparam int ST_ERRPIN = 4;

  // ----------------------------------------
  // Status readback layout in the shift register
  // ----------------------------------------
  localparam int SID_LOD_MSB = 191; // Open-LED bits, channel 15 first
  localparam int SID_TEF     = 175; // Thermal flag after them

  // APB slave states
  typedef enum logic [1:0] {
    AP_IDLE = 2'b01,
    AP_RESP = 2'b10
  } ledd_apb_e;

  // Stagger in cycles for one channel, rounded up
  function automatic int chanDelay(input int idx);
    return (idx * STEP_NS + CLK_NS - 1) / CLK_NS;
  endfunction

endpackage

// [shared/ledd_chan_if.sv]
// Channel switching signals between control logic and stagger stage
`timescale 1ns/1ps
interface ledd_chan_if;
  logic [15:0] rawOn;  // Undelayed on request per channel
  logic [15:0] chanOn; // Staggered on state per channel
  modport drv (output rawOn, input chanOn);
  modport stg (input rawOn, output chanOn);
endinterface

// [verilog/ledd_stagger.sv]
// Per-channel switching delay line for inrush control
`timescale 1ns/1ps
module ledd_stagger (
  input wire logic mclk,
  input wire logic rst,
  ledd_chan_if.stg ch
);

  // ----------------------------------------
  // History of on requests
  // ----------------------------------------
  // Row k holds the requests of k+1 cycles ago
  logic [15:0] hist_ff [0:ledd_pkg::MAX_DLY];

  // Shift the history; on and off edges see the same delay
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int k = 0; k <= ledd_pkg::MAX_DLY; k++) begin
        hist_ff[k] <= 16'h0000;
      end
    end else begin
      hist_ff[0] <= ch.rawOn;
      for (int k = 1; k <= ledd_pkg::MAX_DLY; k++) begin
        hist_ff[k] <= hist_ff[k-1];
      end
    end
  end

  // Tap each channel at index times the step
  always_comb begin
    for (int n = 0; n < ledd_pkg::NCH; n++) begin
      if (ledd_pkg::chanDelay(n) == 0) begin
        ch.chanOn[n] = ch.rawOn[n];
      end else begin
        ch.chanOn[n] = hist_ff[ledd_pkg::chanDelay(n) - 1][n];
      end
    end
  end

  // Channel 0 is undelayed, channel 15 lags by the full span
  AST_STAG_FIRST: assert property (@(posedge mclk) disable iff (rst)
    ch.chanOn[0] == ch.rawOn[0]) else $error("Channel 0 delayed");
  AST_STAG_LAST: assert property (@(posedge mclk) disable iff (rst)
    $past(rst, 40) == 1'b0 |-> ch.chanOn[15] == $past(ch.rawOn[15], 38))
    else $error("Channel 15 stagger wrong");

endmodule

// [verification/ledd_host_model.sv]
// Host controller model that drives the serial side of the LED driver
`timescale 1ns/1ps
module ledd_host_model (
  input  wire logic mclk,
  input  wire logic serialOut,
  output logic      shiftClk,
  output logic      serialIn,
  output logic      latchStrobe
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [191:0] rdBits; // Bits returned by the far end, MSB first

  // Shift clock stands low between frames
  initial begin
    shiftClk    = 1'b0;
    serialIn    = 1'b0;
    latchStrobe = 1'b0;
    rdBits      = '0;
  end

  // ------------------------------------------------------------
  // Frame tasks, entered just after a rising mclk edge
  // ------------------------------------------------------------
  // Send n bits and capture the returned stream; 80 ns shift period
  task automatic shiftWord(input logic [191:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serialIn <= d[i]; // Top bit goes first
      repeat (5) @(posedge mclk);
      rdBits[i] = serialOut; // Read before the rise
      shiftClk <= 1'b1;
      repeat (5) @(posedge mclk);
      shiftClk <= 1'b0;
    end
    // Idle line shows the inverse, so no stale bit can pass as valid
    serialIn <= ~d[0];
    @(posedge mclk);
  endtask

  // Strobe pulse with clock and data still; callers may latch mid-cycle, as t_status does
  task automatic pulseLatch;
    latchStrobe <= 1'b1;
    repeat (8) @(posedge mclk);
    latchStrobe <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// [verification/test_led_driver_serial_and_error_logic.sv]
// Self-checking testbench for the LED driver control logic
`timescale 1ns/1ps
module test_led_driver_serial_and_error_logic;
  // ------------------------------------------------------------
  // Signals and data
  // ------------------------------------------------------------
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        shiftClk, serialIn, latchStrobe, blank, modeSelect;
  logic        pwmRefClock, overTemp, serialOut, errorOutNOut, errorOutNOe;
  logic [15:0] openSense, channelOutput;
  wire logic   errorOutNIn;
  logic        pwmRun;      // Runs the grayscale reference clock
  int          checks, miscompares;
  // Channels 0 and 15 full, channel 5 short; second word has channel 5 full
  localparam logic [191:0] GS_A = {12'hfff, 108'h0, 12'h010, 48'h0, 12'hfff};
  localparam logic [191:0] GS_B = {12'hfff, 108'h0, 12'hfff, 48'h0, 12'hfff};
  localparam logic [191:0] PAT  = {6{32'hc3a5_0f96}};

  // Pull-up on the open-drain error wire
  assign errorOutNIn = errorOutNOe ? errorOutNOut : 1'b1;

  ledd_core ledd_core_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shiftClk(shiftClk), .serialIn(serialIn),
    .latchStrobe(latchStrobe), .blank(blank), .modeSelect(modeSelect),
    .pwmRefClock(pwmRefClock), .overTemp(overTemp), .openSense(openSense),
    .errorOutNIn(errorOutNIn), .serialOut(serialOut), .errorOutNOut(errorOutNOut),
    .errorOutNOe(errorOutNOe), .channelOutput(channelOutput));

  ledd_host_model ledd_host_model_i (.mclk(mclk), .serialOut(serialOut),
    .shiftClk(shiftClk), .serialIn(serialIn), .latchStrobe(latchStrobe));

  // ------------------------------------------------------------
  // Clocks
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Reference clock toggles every cycle while enabled
  always @(posedge mclk) begin
    if (pwmRun) begin
      pwmRefClock <= ~pwmRefClock;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [191:0] exp, input logic [191:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the release reach an edge before the next setup
    @(posedge mclk);
    check("apb answer", 192'(2), 192'(n)); // One wait state
  endtask

  task automatic waitOe(input logic v, input int lim, output int n);
    n = 0;
    while (errorOutNOe !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // Stagger in cycles, rounded up
  function automatic int stagger(input int idx);
    return (idx * ledd_pkg::STEP_NS + ledd_pkg::CLK_NS - 1) / ledd_pkg::CLK_NS;
  endfunction

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_apb;
    logic [31:0] rd;
    logic        err;
    apb(1'b0, ledd_pkg::ADR_CTRL, 32'h0, rd, err);
    check("ctrl reset", 192'(32'h1), 192'(rd));
    // Blank pin high and error wire released after reset
    apb(1'b0, ledd_pkg::ADR_STATUS, 32'h0, rd, err);
    check("status reg", 192'(32'h18), 192'(rd));
    apb(1'b1, ledd_pkg::ADR_CTRL, 32'h2, rd, err);
    apb(1'b0, ledd_pkg::ADR_CTRL, 32'h0, rd, err);
    check("ctrl write", 192'(32'h2), 192'(rd));
    // Restore error enable, software blanking off
    apb(1'b1, ledd_pkg::ADR_CTRL, 32'h1, rd, err);
    apb(1'b0, 8'h40, 32'h0, rd, err);
    check("unmapped", 192'(33'h1_0000_0000), 192'({err, rd}));
  endtask

  // Cascade: a second frame pushes the first one out unchanged
  task automatic t_chain;
    ledd_host_model_i.shiftWord(PAT, 192);
    ledd_host_model_i.shiftWord(GS_A, 192);
    check("gs chain", PAT, ledd_host_model_i.rdBits);
    ledd_host_model_i.pulseLatch();
  endtask

  // Turn-on spread measured from channel 0
  task automatic t_stagger;
    int n, t5, t15;
    blank <= 1'b0;
    n = 0;
    while (channelOutput[0] !== 1'b1 && n < 30) begin
      @(posedge mclk);
      n++;
    end
    t5  = -1;
    t15 = -1;
    for (n = 1; n < 60; n++) begin
      @(posedge mclk);
      if (t5 < 0 && channelOutput[5] === 1'b1) begin
        t5 = n;
      end
      if (t15 < 0 && channelOutput[15] === 1'b1) begin
        t15 = n;
      end
    end
    check("ch5 delay", 192'(stagger(5)), 192'(t5));
    check("ch15 delay", 192'(stagger(15)), 192'(t15));
  endtask

  task automatic t_blank;
    logic [31:0] rd;
    logic        err;
    pwmRun <= 1'b1;
    repeat (100) @(posedge mclk);
    check("short channel ends", 192'(2'b01), 192'({channelOutput[5], channelOutput[0]}));
    blank <= 1'b1;
    repeat (45) @(posedge mclk);
    check("blanked outputs", 192'(0), 192'(channelOutput));
    apb(1'b0, ledd_pkg::ADR_PWMCNT, 32'h0, rd, err);
    check("count held", 192'(0), 192'(rd));
  endtask

  task automatic t_error;
    int n;
    openSense <= 16'h0003;
    overTemp  <= 1'b1;
    waitOe(1'b1, 12, n);
    check("thermal while blanked", 192'(1), 192'(errorOutNOe));
    overTemp <= 1'b0;
    repeat (20) @(posedge mclk);
    check("open masked", 192'(0), 192'(errorOutNOe));
    blank <= 1'b0;
    waitOe(1'b1, 300, n);
    check("open delay", 192'(1), 192'(n >= 125 && n <= 140));
    // Mask must act while the open bits are still live, before the channel goes dark
    blank <= 1'b1;
    repeat (4) @(posedge mclk);
    check("open masked live", 192'(0), 192'(errorOutNOe));
    blank <= 1'b0;
  endtask

  // Mid-cycle latch, then status capture and readback
  task automatic t_status;
    logic [191:0] status_readback;
    overTemp <= 1'b1;
    ledd_host_model_i.shiftWord(GS_B, 192);
    ledd_host_model_i.pulseLatch();
    repeat (50) @(posedge mclk);
    check("new gs at once", 192'(1), 192'(channelOutput[5]));
    ledd_host_model_i.shiftWord(GS_B, 192);
    status_readback      = '0;
    status_readback[176] = 1'b1;
    status_readback[175] = 1'b1;
    check("status", status_readback, ledd_host_model_i.rdBits);
    overTemp <= 1'b0;
    pwmRun   <= 1'b0;
  endtask

  // Short register in correction mode; latch leaves grayscale alone
  task automatic t_dc;
    logic [15:0] prev;
    modeSelect <= 1'b1;
    repeat (10) @(posedge mclk);
    ledd_host_model_i.shiftWord(PAT, 96);
    ledd_host_model_i.shiftWord(~PAT, 96);
    check("dc chain", 192'(PAT[95:0]), 192'(ledd_host_model_i.rdBits[95:0]));
    prev = channelOutput;
    ledd_host_model_i.pulseLatch();
    check("dc latch", 192'(prev), 192'(channelOutput));
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is near 10k cycles; cut off well beyond it
  initial begin
    #400_000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {blank, modeSelect, pwmRefClock, overTemp, pwmRun} = 5'b10000;
    openSense   = 16'h0;
    checks      = 0;
    miscompares = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_apb();
    t_chain();
    t_stagger();
    t_blank();
    t_error();
    t_status();
    t_dc();
    report_and_stop();
  end
endmodule
